// [hw/correction_core.sv]
`timescale 1ns/100ps
`default_nettype none
`include "meas_cmd_consts.svh"

// ==========================================================
// math core: raw * gain (fixed point) + offset, saturated
module correction_core #(
	parameter int WIDTH = `RESULT_WIDTH,
	parameter int FRAC = `GAIN_FRAC_BITS
) (
	input wire logic signed [WIDTH-1:0] raw_i, // raw converter value
	input wire logic signed [WIDTH-1:0] gain_i, // calibration gain, FRAC fraction bits
	input wire logic signed [WIDTH-1:0] offset_i, // calibration offset
	output logic signed [WIDTH-1:0] corr_o // corrected value
);
	localparam logic signed [2*WIDTH:0] MAX_V = (2*WIDTH+1)'((64'sd1 <<< (WIDTH-1)) - 1);
	localparam logic signed [2*WIDTH:0] MIN_V = (2*WIDTH+1)'(-(64'sd1 <<< (WIDTH-1)));

	logic signed [2*WIDTH:0] prod;
	logic signed [2*WIDTH:0] sum;

	// apply coefficients and clamp to the signed result range
	always_comb begin
		// widen both factors first so the product keeps all of its bits
		prod = ((2*WIDTH+1)'(raw_i) * (2*WIDTH+1)'(gain_i)) >>> FRAC;
		sum = prod + (2*WIDTH+1)'(offset_i);
		if (sum > MAX_V) begin
			corr_o = MAX_V[WIDTH-1:0];
		end else if (sum < MIN_V) begin
			corr_o = MIN_V[WIDTH-1:0];
		end else begin
			corr_o = sum[WIDTH-1:0];
		end
	end
endmodule

`default_nettype wire

// [hw/meas_cmd_consts.svh]
`ifndef MEAS_CMD_CONSTS_SVH
`define MEAS_CMD_CONSTS_SVH

// ==========================================================
// command byte codes
`define CMD_RAW_SENSOR 8'ha2
`define CMD_RAW_TEMP 8'ha4
`define CMD_COMMAND_MODE 8'ha9
`define CMD_MEASURE 8'haa
`define CMD_MEASURE_CYCLIC 8'hab
`define CMD_OVERSAMPLE_2 8'hac
`define CMD_OVERSAMPLE_4 8'had
`define CMD_OVERSAMPLE_8 8'hae
`define CMD_OVERSAMPLE_16 8'haf
`define CMD_HALT_PERIODIC 8'hbf

// ==========================================================
// result layout and math core format
`define RESULT_WIDTH 24
`define RESULT_BYTES 3
`define AVG_HEADROOM 4
`define GAIN_FRAC_BITS 16

// ==========================================================
// timing
`define CLK_FREQ_KHZ 40000
`define CYCLIC_PERIOD_US 1000
`define CYCLIC_PERIOD_CYCLES ((`CYCLIC_PERIOD_US * `CLK_FREQ_KHZ) / 1000)

`endif

// [hw/meas_cmd_pkg.sv]
`include "meas_cmd_consts.svh"

package meas_cmd_pkg;

	// one-hot sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CONV = 4'h2,
		ST_CORR = 4'h4,
		ST_WAIT = 4'h8
	} meas_state_t;

	// complete state of the command handler
	typedef struct packed {
		meas_state_t st;
		logic busy;
		logic cyclic;
		logic command_mode;
		logic raw_mode;
		logic temp_sel;
		logic conv_start;
		logic cal_ok;
		logic [4:0] avg_left;
		logic [2:0] avg_shift;
		logic signed [`RESULT_WIDTH-1:0] raw;
		logic signed [`RESULT_WIDTH+`AVG_HEADROOM-1:0] acc;
		logic signed [`RESULT_WIDTH-1:0] result;
		logic [7:0] rd_byte;
		logic [31:0] wait_cnt;
	} meas_regs_t;

endpackage

// [hw/sensor_measurement_commands.sv]
`timescale 1ns/100ps
`default_nettype none
`include "meas_cmd_consts.svh"

module sensor_measurement_commands
	import meas_cmd_pkg::*;
#(
	parameter int WIDTH = `RESULT_WIDTH,
	parameter int CYCLIC_PERIOD = `CYCLIC_PERIOD_CYCLES
) (
	input wire logic clk_sys_i, // system clock, 40 MHz
	input wire logic reset_n_i, // asynchronous reset, active low
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic cmd_valid_i, // one-cycle strobe: command byte present
	input wire logic [7:0] cmd_byte_i, // command byte from serial front end
	output logic conv_start_o, // one-cycle pulse: start a conversion
	output logic conv_temp_o, // conversion channel: 1 temperature, 0 sensor
	input wire logic conv_done_i, // one-cycle pulse: conversion finished
	input wire logic [WIDTH-1:0] conv_data_i, // converter result, signed
	input wire logic [WIDTH-1:0] cal_gain_i, // calibration gain coefficient
	input wire logic [WIDTH-1:0] cal_offset_i, // calibration offset coefficient
	input wire logic cal_valid_i, // calibration coefficients stored
	input wire logic [1:0] rd_sel_i, // result byte select, 0 = most significant
	output logic [7:0] rd_byte_o, // selected result byte
	output logic [WIDTH-1:0] result_o, // full result word
	output logic result_cal_ok_o, // last corrected result used valid calibration
	output logic busy_o, // measurement in progress
	output logic cyclic_mode_o, // cyclic mode active
	output logic command_mode_o // command mode active
);
	// last count of the scheduler gap; the counter restarts at each result
	localparam logic [31:0] PERIOD_LAST = 32'(CYCLIC_PERIOD - 1);

	// registered state and its next value
	meas_regs_t s_reg;
	meas_regs_t s_next;
	// math core answer and running sum of corrected samples
	logic signed [WIDTH-1:0] corr;
	logic signed [WIDTH+`AVG_HEADROOM-1:0] acc_sum;

	// oversampling exponent for a full measurement command
	// a plain measure averages one sample, so its shift is zero
	function automatic logic [2:0] avg_exp(input logic [7:0] cmd);
		case (cmd)
			`CMD_OVERSAMPLE_2: avg_exp = 3'h1;
			`CMD_OVERSAMPLE_4: avg_exp = 3'h2;
			`CMD_OVERSAMPLE_8: avg_exp = 3'h3;
			`CMD_OVERSAMPLE_16: avg_exp = 3'h4;
			default: avg_exp = 3'h0;
		endcase
	endfunction

	// ==========================================================
	// math core
	correction_core #(
		.WIDTH(WIDTH),
		.FRAC(`GAIN_FRAC_BITS)
	) u_core (
		.raw_i(s_reg.raw),
		.gain_i(cal_gain_i),
		.offset_i(cal_offset_i),
		.corr_o(corr)
	);

	// the sample is sign-extended before it joins the sum
	assign acc_sum = s_reg.acc + (WIDTH+`AVG_HEADROOM)'(corr);

	// ==========================================================
	// command decode and measurement sequencer
	always_comb begin
		s_next = s_reg;
		s_next.conv_start = 1'b0;
		case (s_reg.st)
			ST_IDLE: begin
				// only an idle handler takes commands, apart from the cyclic halt handled below
				if (cmd_valid_i) begin
					case (cmd_byte_i)
						`CMD_RAW_SENSOR, `CMD_RAW_TEMP: begin
							// raw words skip the core
							s_next.raw_mode = 1'b1;
							s_next.temp_sel = (cmd_byte_i == `CMD_RAW_TEMP);
							s_next.conv_start = 1'b1;
							s_next.busy = 1'b1;
							s_next.st = ST_CONV;
						end
						`CMD_MEASURE, `CMD_OVERSAMPLE_2, `CMD_OVERSAMPLE_4,
						`CMD_OVERSAMPLE_8, `CMD_OVERSAMPLE_16: begin
							s_next.raw_mode = 1'b0;
							s_next.temp_sel = 1'b0;
							s_next.avg_shift = avg_exp(cmd_byte_i);
							s_next.avg_left = 5'h01 << avg_exp(cmd_byte_i);
							s_next.acc = '0;
							s_next.conv_start = 1'b1;
							s_next.busy = 1'b1;
							s_next.st = ST_CONV;
						end
						`CMD_MEASURE_CYCLIC: begin
							s_next.cyclic = 1'b1;
							s_next.command_mode = 1'b0;
							s_next.raw_mode = 1'b0;
							s_next.temp_sel = 1'b0;
							s_next.avg_shift = 3'h0;
							s_next.avg_left = 5'h01;
							s_next.acc = '0;
							s_next.conv_start = 1'b1;
							s_next.busy = 1'b1;
							s_next.st = ST_CONV;
						end
						`CMD_COMMAND_MODE: begin
							s_next.command_mode = 1'b1;
						end
						default: begin
						end
					endcase
				end
			end
			ST_CONV: begin
				// capture the converter word
				// answers are only taken here, so a late one after a halt is dropped
				if (conv_done_i) begin
					s_next.raw = conv_data_i;
					if (s_reg.raw_mode) begin
						s_next.result = conv_data_i;
						s_next.busy = 1'b0;
						s_next.st = ST_IDLE;
					end else begin
						s_next.st = ST_CORR;
					end
				end
			end
			ST_CORR: begin
				// accumulate corrected samples, mean on the last one
				// the core reads the stored raw word, not the live converter bus
				s_next.acc = acc_sum;
				if (s_reg.avg_left == 5'h01) begin
					s_next.result = WIDTH'(acc_sum >>> s_reg.avg_shift);
					s_next.cal_ok = cal_valid_i;
					if (s_reg.cyclic) begin
						s_next.wait_cnt = '0;
						s_next.st = ST_WAIT;
					end else begin
						s_next.busy = 1'b0;
						s_next.st = ST_IDLE;
					end
				end else begin
					s_next.avg_left = s_reg.avg_left - 5'h01;
					s_next.conv_start = 1'b1;
					s_next.st = ST_CONV;
				end
			end
			ST_WAIT: begin
				// scheduler interval between self-triggered measurements
				// cyclic mode takes single samples and keeps busy set in the gap
				s_next.wait_cnt = s_reg.wait_cnt + 32'h00000001;
				if (s_reg.wait_cnt >= PERIOD_LAST) begin
					s_next.acc = '0;
					s_next.avg_left = 5'h01;
					s_next.conv_start = 1'b1;
					s_next.st = ST_CONV;
				end
			end
			default: begin
				s_next.st = ST_IDLE;
				s_next.busy = 1'b0;
			end
		endcase
		// the halt command is honoured even though cyclic mode is busy
		// a conversion in flight is abandoned; its answer finds the handler idle
		if (cmd_valid_i && cmd_byte_i == `CMD_HALT_PERIODIC && s_reg.cyclic) begin
			s_next.cyclic = 1'b0;
			s_next.busy = 1'b0;
			s_next.conv_start = 1'b0;
			s_next.st = ST_IDLE;
		end
		// result byte lane select, most significant byte first
		// lane 3 reads as zero
		case (rd_sel_i)
			2'h0: s_next.rd_byte = s_reg.result[23:16];
			2'h1: s_next.rd_byte = s_reg.result[15:8];
			2'h2: s_next.rd_byte = s_reg.result[7:0];
			default: s_next.rd_byte = 8'h00;
		endcase
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			// the handler wakes idle and in command mode
			s_reg <= '{st: ST_IDLE, command_mode: 1'b1, default: '0};
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// outputs straight from the state register
	assign conv_start_o = s_reg.conv_start;
	assign conv_temp_o = s_reg.temp_sel;
	assign rd_byte_o = s_reg.rd_byte;
	assign result_o = s_reg.result;
	assign result_cal_ok_o = s_reg.cal_ok;
	assign busy_o = s_reg.busy;
	assign cyclic_mode_o = s_reg.cyclic;
	assign command_mode_o = s_reg.command_mode;
endmodule

`default_nettype wire

// [tb/conv_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// converter model: answers each start after lat_i cycles
module conv_model (
	input wire logic clk_i, // clock
	input wire logic start_i, // start pulse
	input wire logic temp_i, // channel
	input wire logic [3:0] lat_i, // latency, at least 1
	input wire logic [23:0] sbase_i, // sensor value
	input wire logic [23:0] tbase_i, // temperature value
	output var logic done_o = 1'b0, // done pulse
	output var logic [23:0] data_o = 24'h0 // data
);
	logic [3:0] cnt = 4'h0;
	logic temp = 1'b0;
	logic ph = 1'b0;
	// every second conversion reads two higher; data flips outside done
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		data_o <= ~data_o;
		if (cnt == 4'h1) begin
			done_o <= 1'b1;
			data_o <= (temp ? tbase_i : sbase_i) + (ph ? 24'h2 : 24'h0);
			ph <= ~ph;
		end
		if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		if (start_i) begin
			cnt <= lat_i;
			temp <= temp_i;
		end
	end
endmodule
`default_nettype wire

// [tb/meas_cmd_props.sv]
`timescale 1ns/100ps
`default_nettype none
`include "meas_cmd_consts.svh"
// ==========================================================
// checker on the command handler ports
module meas_cmd_props #(parameter int WIDTH = `RESULT_WIDTH) (
	input wire logic clk_sys_i, // clock
	input wire logic reset_n_i, // reset
	input wire logic cmd_valid_i, // strobe
	input wire logic [7:0] cmd_byte_i, // code
	input wire logic conv_start_o, // start
	input wire logic conv_temp_o, // channel
	input wire logic conv_done_i, // done
	input wire logic [1:0] rd_sel_i, // select
	input wire logic [7:0] rd_byte_o, // byte
	input wire logic [WIDTH-1:0] result_o, // result
	input wire logic busy_o, // busy
	input wire logic cyclic_mode_o, // cyclic
	input wire logic command_mode_o // mode
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	logic go;
	// a command that the idle handler takes
	assign go = cmd_valid_i && !busy_o;
	// command effects, refusals and byte selection
	a_meas_start: assert property (go && cmd_byte_i == `CMD_MEASURE |=> busy_o && conv_start_o
		&& !conv_temp_o) else $error("measure start wrong");
	a_temp_chan: assert property (go && cmd_byte_i == `CMD_RAW_TEMP |=> busy_o && conv_start_o
		&& conv_temp_o) else $error("temperature start wrong");
	a_cyc_enter: assert property (go && cmd_byte_i == `CMD_MEASURE_CYCLIC |=> cyclic_mode_o
		&& !command_mode_o && conv_start_o) else $error("cyclic entry wrong");
	a_cyc_busy: assert property (cyclic_mode_o |-> busy_o) else $error("busy low in cyclic");
	a_halt_cyc: assert property (cyclic_mode_o && cmd_valid_i && cmd_byte_i == `CMD_HALT_PERIODIC
		|=> !cyclic_mode_o && !busy_o) else $error("halt not obeyed");
	a_cmd_mode: assert property (go && cmd_byte_i == `CMD_COMMAND_MODE |=> command_mode_o)
		else $error("command mode not set");
	a_busy_drop: assert property (busy_o && !cyclic_mode_o && cmd_valid_i && !conv_done_i
		&& !$past(conv_done_i) |=> !conv_start_o) else $error("command taken while busy");
	a_byte_sel: assert property (rd_sel_i != 2'h3 |=> rd_byte_o == $past(8'(result_o
		>> (5'h10 - 5'h08 * rd_sel_i)))) else $error("result byte wrong");
endmodule
bind sensor_measurement_commands meas_cmd_props #(.WIDTH(WIDTH)) meas_cmd_props_inst (
	.clk_sys_i, .reset_n_i, .cmd_valid_i, .cmd_byte_i, .conv_start_o, .conv_temp_o, .conv_done_i,
	.rd_sel_i, .rd_byte_o, .result_o, .busy_o, .cyclic_mode_o, .command_mode_o);
`default_nettype wire

// [tb/sensor_measurement_commands_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "meas_cmd_consts.svh"
module sensor_measurement_commands_test;
	logic clk_sys_i = 1'b0, reset_n_i = 1'b0, cmd_valid_i = 1'b0, cal_valid_i = 1'b1;
	logic conv_start_o, conv_temp_o, conv_done_i, result_cal_ok_o, busy_o, cyclic_mode_o;
	logic command_mode_o;
	logic [7:0] cmd_byte_i = 8'h0, rd_byte_o;
	logic [1:0] rd_sel_i = 2'h0;
	logic [3:0] lat = 4'h3;
	logic [23:0] sb = 24'h800000, tb = 24'h7ffffd, gain = 24'h010000, offs = 24'h000010;
	logic [23:0] result_o, conv_data_i;
	int fails = 0, compares = 0, n_done = 0, n_start = 0;
	sensor_measurement_commands #(.CYCLIC_PERIOD(8)) sensor_measurement_commands_inst (
		.clk_sys_i, .reset_n_i, .ce_i(1'b1), .cmd_valid_i, .cmd_byte_i, .conv_start_o,
		.conv_temp_o, .conv_done_i, .conv_data_i, .cal_gain_i(gain), .cal_offset_i(offs),
		.cal_valid_i, .rd_sel_i, .rd_byte_o, .result_o, .result_cal_ok_o, .busy_o,
		.cyclic_mode_o, .command_mode_o);
	conv_model conv_model_inst (.clk_i(clk_sys_i), .start_i(conv_start_o), .temp_i(conv_temp_o),
		.lat_i(lat), .sbase_i(sb), .tbase_i(tb), .done_o(conv_done_i), .data_o(conv_data_i));
	// clock and conversion counters
	initial forever #12.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		n_done <= n_done + (conv_done_i === 1'b1);
		n_start <= n_start + (conv_start_o === 1'b1);
	end
	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic send(input logic [7:0] c);
		@(posedge clk_sys_i) #1;
		cmd_valid_i = 1'b1;
		cmd_byte_i = c;
		@(posedge clk_sys_i) #1;
		cmd_valid_i = 1'b0;
	endtask
	task automatic wait_idle(output int n);
		for (n = 0; n < 400 && busy_o !== 1'b0; n++)
			@(posedge clk_sys_i) #1;
		if (n == 400) begin
			fails++;
			end_sim();
		end
	endtask
	task automatic read_res(input logic [23:0] e);
		for (int k = 0; k < 3; k++) begin
			rd_sel_i = 2'(k);
			@(posedge clk_sys_i) #1;
			chk(24'(rd_byte_o), 24'(e[23 - 8 * k -: 8]));
		end
		rd_sel_i = 2'h3;
		@(posedge clk_sys_i) #1;
		chk(24'(rd_byte_o), 24'h0);
		chk(result_o, e);
	endtask
	// raw sensor then raw temperature, then corrected with a refused command
	task automatic t_single();
		int n, s;
		send(`CMD_RAW_SENSOR);
		chk(24'(conv_temp_o), 24'h0);
		wait_idle(n);
		read_res(sb);
		send(`CMD_RAW_TEMP);
		chk(24'(conv_temp_o), 24'h1);
		wait_idle(n);
		read_res(tb + 24'h2);
		s = n_start;
		send(`CMD_MEASURE);
		send(`CMD_RAW_TEMP);
		wait_idle(n);
		chk(24'({n_start - s, conv_temp_o}), 24'h2);
		read_res(sb + offs);
		chk(24'(result_cal_ok_o), 24'h1);
		$display("test single end");
	endtask
	// every oversample code, prompt and slow converter
	task automatic t_avg();
		int n, s, d;
		logic [7:0] c[4] = '{`CMD_OVERSAMPLE_2, `CMD_OVERSAMPLE_4, `CMD_OVERSAMPLE_8,
			`CMD_OVERSAMPLE_16};
		for (int i = 0; i < 4; i++) begin
			cal_valid_i = (i != 0);
			lat = i[0] ? 4'h1 : 4'h6;
			s = n_start;
			d = n_done;
			send(c[i]);
			wait_idle(n);
			chk(24'(n_start - s), 24'(2 << i));
			chk(24'(n_done - d), 24'(2 << i));
			chk(24'(n >= (2 << i) * lat), 24'h1);
			read_res(sb + offs + 24'h1);
			chk(24'(result_cal_ok_o), 24'(cal_valid_i));
		end
		lat = 4'h3;
		$display("test average end");
	endtask
	// cyclic entry, host only reads, halt then command mode
	task automatic t_cyc();
		int n, s;
		s = n_start;
		send(`CMD_MEASURE_CYCLIC);
		for (n = 0; n < 200 && n_start - s < 3; n++) begin
			chk(24'({busy_o, cyclic_mode_o, command_mode_o}), 24'h6);
			rd_sel_i = 2'(n % 3);
			@(posedge clk_sys_i) #1;
		end
		chk(24'(n_start - s), 24'h3);
		send(`CMD_HALT_PERIODIC);
		chk(24'({busy_o, cyclic_mode_o}), 24'h0);
		s = n_start;
		repeat (30) @(posedge clk_sys_i);
		#1 chk(24'(n_start - s), 24'h0);
		send(`CMD_COMMAND_MODE);
		chk(24'(command_mode_o), 24'h1);
		$display("test cyclic end");
	endtask
	task automatic end_sim();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// reset, then the scenarios
	initial begin
		repeat (6) @(posedge clk_sys_i);
		#1 reset_n_i = 1'b1;
		t_single();
		t_avg();
		t_cyc();
		end_sim();
	end
endmodule
`default_nettype wire
